// file: design/uart_line_format_control.sv
// uart line format, modem outputs, trigger table and fifo buffering
// What this block does
// - word-length field 00..11 gives 5..8 data bits, default five
// - stop select: one stop bit, else 1.5 for five bits, two otherwise
// - parity enable adds parity on transmit and checks it on receive
// - unforced parity: type 0 odd, type 1 even
// - forced parity: type 0 sends mark, type 1 sends space
// - break bit holds transmit line low until cleared
// - divisor-access bit maps data addresses onto divisor latch
// - terminal-ready output is inverse of its control bit
// - request-to-send output is inverse of its control bit
// - auto flow control lets receive fill level drive request-to-send
// - one trigger table selection serves both directions
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module sync_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  // full count needs the extra bit; an AW-wide compare would wrap to zero
  localparam logic [AW:0] FULL_CNT = D[AW:0];
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // honest full and empty straight from the fill count
  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign count = cnt_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset, entries are only read once written
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule : sync_fifo

////////////////////////////////////////////////////////////////////////////
module uart_line_format_control #(
  parameter int DEPTH = uart_fmt_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic txd,
  input wire logic rxd,
  output logic dtr_n,
  output logic rts_n
);
  import uart_fmt_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;

  logic [7:0] lfc_r, lfc_nxt, moc_r, moc_nxt, qctl_r, qctl_nxt;
  logic [7:0] ftt_r, ftt_nxt, efc_r, efc_nxt;
  logic [7:0] trg_rx_r, trg_rx_nxt, trg_tx_r, trg_tx_nxt;
  logic [15:0] div_r, div_nxt, divm1;
  logic [31:0] prdata_r, prdata_nxt;
  logic setup, access, done, dlab, hit, is_data;
  logic [7:0] rx_trig, tx_trig;
  fmt_t fmt;
  logic txq_valid, txq_ready, txq_ovalid, txq_pop;
  logic [7:0] txq_data;
  logic [CW-1:0] txq_cnt, rxq_cnt;
  logic rxq_ivalid, rxq_iready, rxq_ovalid, rxq_pop;
  rx_word_t rxq_in, rxq_out;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign dlab = lfc_r[LFC_DLAB];
  assign is_data = (paddr == ADDR_DATA) & ~dlab;
  // a data write waits while the transmit fifo is full
  assign pready = ~(is_data & pwrite & ~txq_ready);
  assign done = access & pready;
  assign hit = (paddr <= ADDR_STAT) & (paddr[1:0] == 2'b00);
  assign pslverr = access & ~hit;
  assign prdata = prdata_r;
  assign txq_valid = done & pwrite & is_data;
  assign rxq_pop = done & ~pwrite & is_data;
  assign divm1 = (div_r == '0) ? '0 : div_r - 1'b1;

  // decoded format shared by both directions
  always_comb begin
    fmt.nbits = NBITS_BASE + {2'b00, lfc_r[1:0]};
    if (!lfc_r[LFC_STOP]) begin
      fmt.stop_halves = STOP_ONE;
    end else if (lfc_r[1:0] == 2'b00) begin
      fmt.stop_halves = STOP_ONEHALF;
    end else begin
      fmt.stop_halves = STOP_TWO;
    end
    fmt.par_en = lfc_r[LFC_PEN];
    fmt.par_type = lfc_r[LFC_PTYPE];
    fmt.par_force = lfc_r[LFC_PFORCE];
  end

  // one table select in ftt serves rx and tx alike
  always_comb begin
    if (ftt_r[5:4] == TBL_PROG) begin
      rx_trig = trg_rx_r;
      tx_trig = trg_tx_r;
    end else begin
      rx_trig = 8'(({6'h00, qctl_r[7:6]} + 8'h01) << TRIG_SHIFT);
      tx_trig = 8'(({6'h00, qctl_r[5:4]} + 8'h01) << TRIG_SHIFT);
    end
  end

  // parity of the masked character for the given format
  function automatic logic par_bit(input logic [7:0] d, input fmt_t f);
    logic [7:0] m;
    m = d & 8'(8'hff >> (4'h8 - f.nbits));
    if (f.par_force) begin
      par_bit = ~f.par_type;
    end else begin
      par_bit = f.par_type ? ^m : ~^m;
    end
  endfunction : par_bit

  //////////////////////////////////////////////////////////////////////////
  // register file writes and read capture
  always_comb begin
    lfc_nxt = lfc_r;
    moc_nxt = moc_r;
    qctl_nxt = qctl_r;
    ftt_nxt = ftt_r;
    efc_nxt = efc_r;
    trg_rx_nxt = trg_rx_r;
    trg_tx_nxt = trg_tx_r;
    div_nxt = div_r;
    prdata_nxt = prdata_r;
    if (done && pwrite) begin
      case (paddr)
        ADDR_DATA: if (dlab) div_nxt[7:0] = pwdata[7:0];
        ADDR_DIVH: if (dlab) div_nxt[15:8] = pwdata[7:0];
        ADDR_QCTL: qctl_nxt = pwdata[7:0];
        ADDR_LFC: lfc_nxt = pwdata[7:0];
        ADDR_MOC: moc_nxt = pwdata[7:0];
        ADDR_FTT: ftt_nxt = pwdata[7:0];
        ADDR_TRG: begin
          if (ftt_r[FTT_TSEL]) begin
            trg_tx_nxt = pwdata[7:0];
          end else begin
            trg_rx_nxt = pwdata[7:0];
          end
        end
        ADDR_EFC: efc_nxt = pwdata[7:0];
        default: ;
      endcase
    end
    if (setup) begin
      prdata_nxt = '0;
      case (paddr)
        ADDR_DATA: begin
          if (dlab) begin
            prdata_nxt[7:0] = div_r[7:0];
          end else if (rxq_ovalid) begin
            // an empty queue reads zero, never unwritten storage
            prdata_nxt[9:0] = rxq_out;
          end
        end
        ADDR_DIVH: if (dlab) prdata_nxt[7:0] = div_r[15:8];
        ADDR_QCTL: prdata_nxt[7:0] = qctl_r;
        ADDR_LFC: prdata_nxt[7:0] = lfc_r;
        ADDR_MOC: prdata_nxt[7:0] = moc_r;
        ADDR_FTT: prdata_nxt[7:0] = ftt_r;
        ADDR_TRG: prdata_nxt[7:0] = ftt_r[FTT_TSEL] ? trg_tx_r : trg_rx_r;
        ADDR_EFC: prdata_nxt[7:0] = efc_r;
        ADDR_STAT: begin
          prdata_nxt[CW-1:0] = txq_cnt;
          prdata_nxt[CW+7:8] = rxq_cnt;
          prdata_nxt[16] = rxq_ovalid;
          prdata_nxt[17] = (txq_cnt < {1'b0, tx_trig});
          prdata_nxt[18] = (rxq_cnt >= {1'b0, rx_trig});
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfc_r <= REG_RST;
      moc_r <= REG_RST;
      qctl_r <= REG_RST;
      ftt_r <= REG_RST;
      efc_r <= REG_RST;
      trg_rx_r <= TRG_RST;
      trg_tx_r <= TRG_RST;
      div_r <= DIV_RST;
      prdata_r <= '0;
    end else begin
      lfc_r <= lfc_nxt;
      moc_r <= moc_nxt;
      qctl_r <= qctl_nxt;
      ftt_r <= ftt_nxt;
      efc_r <= efc_nxt;
      trg_rx_r <= trg_rx_nxt;
      trg_tx_r <= trg_tx_nxt;
      div_r <= div_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // modem outputs, registered so they never glitch
  logic dtr_n_r, rts_n_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dtr_n_r <= 1'b1;
      rts_n_r <= 1'b1;
    end else begin
      dtr_n_r <= ~moc_r[MOC_DTR];
      rts_n_r <= efc_r[EFC_ARTS] ? (rxq_cnt >= {1'b0, rx_trig})
               : ~moc_r[MOC_RTS];
    end
  end
  assign dtr_n = dtr_n_r;
  assign rts_n = rts_n_r;

  //////////////////////////////////////////////////////////////////////////
  sync_fifo #(.W(8), .D(DEPTH)) tx_q (
    .clk(clk), .resetn(resetn),
    .in_valid(txq_valid), .in_ready(txq_ready), .in_data(pwdata[7:0]),
    .out_valid(txq_ovalid), .out_ready(txq_pop), .out_data(txq_data),
    .count(txq_cnt)
  );
  sync_fifo #(.W(10), .D(DEPTH)) rx_q (
    .clk(clk), .resetn(resetn),
    .in_valid(rxq_ivalid), .in_ready(rxq_iready), .in_data(rxq_in),
    .out_valid(rxq_ovalid), .out_ready(rxq_pop), .out_data(rxq_out),
    .count(rxq_cnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // transmitter, timed in half-bit ticks so 1.5 stop bits fall out
  ser_state_t tx_st_r, tx_st_nxt;
  logic [15:0] tx_cnt_r, tx_cnt_nxt;
  logic [2:0] tx_half_r, tx_half_nxt;
  logic [3:0] tx_bit_r, tx_bit_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic tx_line_r, tx_line_nxt, txd_r, tx_tick;

  assign tx_tick = (tx_cnt_r == '0);
  assign txq_pop = (tx_st_r == S_IDLE) & txq_ovalid & ~lfc_r[LFC_BRK];

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_cnt_nxt = tx_tick ? divm1 : tx_cnt_r - 1'b1;
    tx_half_nxt = tx_half_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    tx_line_nxt = tx_line_r;
    if (tx_st_r != S_IDLE && tx_tick && tx_half_r > 3'h1) begin
      tx_half_nxt = tx_half_r - 1'b1;
    end else if (tx_st_r == S_IDLE || tx_tick) begin
      tx_half_nxt = HALF_BIT;
      case (tx_st_r)
        S_IDLE: begin
          tx_cnt_nxt = divm1;
          if (txq_pop) begin
            tx_st_nxt = S_START;
            tx_sh_nxt = txq_data;
            tx_line_nxt = 1'b0;
          end
        end
        S_START: begin
          tx_st_nxt = S_DATA;
          tx_bit_nxt = '0;
          tx_line_nxt = tx_sh_r[0];
        end
        S_DATA: begin
          if (tx_bit_r == fmt.nbits - 1'b1) begin
            if (fmt.par_en) begin
              tx_st_nxt = S_PAR;
              tx_line_nxt = par_bit(tx_sh_r, fmt);
            end else begin
              tx_st_nxt = S_STOP;
              tx_half_nxt = fmt.stop_halves;
              tx_line_nxt = 1'b1;
            end
          end else begin
            tx_bit_nxt = tx_bit_r + 1'b1;
            tx_line_nxt = tx_sh_r[tx_bit_r[2:0] + 3'h1];
          end
        end
        S_PAR: begin
          tx_st_nxt = S_STOP;
          tx_half_nxt = fmt.stop_halves;
          tx_line_nxt = 1'b1;
        end
        S_STOP: tx_st_nxt = S_IDLE;
        default: tx_st_nxt = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_r <= S_IDLE;
      tx_cnt_r <= '0;
      tx_half_r <= HALF_BIT;
      tx_bit_r <= '0;
      tx_sh_r <= '0;
      tx_line_r <= 1'b1;
      txd_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_half_r <= tx_half_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_line_r <= tx_line_nxt;
      txd_r <= tx_line_nxt & ~lfc_nxt[LFC_BRK];
    end
  end
  assign txd = txd_r;

  //////////////////////////////////////////////////////////////////////////
  // receiver: three-stage sync, level accepted when stages 2 and 3 agree
  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r, rx_lvl_nxt;
  ser_state_t rx_st_r, rx_st_nxt;
  logic [15:0] rx_cnt_r, rx_cnt_nxt;
  logic [2:0] rx_half_r, rx_half_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic rx_perr_r, rx_perr_nxt, rx_tick, rx_smp;

  assign rx_tick = (rx_cnt_r == '0);
  assign rx_smp = rx_tick & (rx_half_r == 3'h1);
  assign rx_lvl_nxt = (rx_s2_r == rx_s3_r) ? rx_s3_r : rx_lvl_r;
  assign rxq_in = '{frame_err: ~rx_lvl_r, par_err: rx_perr_r,
                    data: rx_sh_r};
  // a full receive fifo drops the character
  assign rxq_ivalid = (rx_st_r == S_STOP) & rx_smp;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_cnt_nxt = rx_tick ? divm1 : rx_cnt_r - 1'b1;
    rx_half_nxt = (rx_tick && rx_half_r > 3'h1) ? rx_half_r - 1'b1
                : rx_half_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_perr_nxt = rx_perr_r;
    if (rx_smp) begin
      rx_half_nxt = HALF_BIT;
    end
    case (rx_st_r)
      S_IDLE: begin
        rx_cnt_nxt = divm1;
        rx_half_nxt = 3'h1; // first sample mid start bit
        if (!rx_lvl_r) begin
          rx_st_nxt = S_START;
        end
      end
      S_START: begin
        if (rx_smp) begin
          rx_st_nxt = rx_lvl_r ? S_IDLE : S_DATA;
          rx_bit_nxt = '0;
          rx_sh_nxt = '0;
        end
      end
      S_DATA: begin
        if (rx_smp) begin
          rx_sh_nxt[rx_bit_r[2:0]] = rx_lvl_r;
          rx_bit_nxt = rx_bit_r + 1'b1;
          if (rx_bit_r == fmt.nbits - 1'b1) begin
            rx_st_nxt = fmt.par_en ? S_PAR : S_STOP;
            rx_perr_nxt = 1'b0;
          end
        end
      end
      S_PAR: begin
        if (rx_smp) begin
          rx_perr_nxt = (rx_lvl_r != par_bit(rx_sh_r, fmt));
          rx_st_nxt = S_STOP;
        end
      end
      S_STOP: if (rx_smp) rx_st_nxt = S_IDLE;
      default: rx_st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_lvl_r <= 1'b1;
      rx_st_r <= S_IDLE;
      rx_cnt_r <= '0;
      rx_half_r <= 3'h1;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_perr_r <= 1'b0;
    end else begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      rx_lvl_r <= rx_lvl_nxt;
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_half_r <= rx_half_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_perr_r <= rx_perr_nxt;
    end
  end
endmodule : uart_line_format_control

// file: design/uart_fmt_pkg.sv
// shared constants and types of the uart line-format block
package uart_fmt_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_DATA = 8'h00; // tx/rx data, divisor low
  localparam logic [7:0] ADDR_DIVH = 8'h04; // divisor high
  localparam logic [7:0] ADDR_QCTL = 8'h08;
  localparam logic [7:0] ADDR_LFC = 8'h0c;
  localparam logic [7:0] ADDR_MOC = 8'h10;
  localparam logic [7:0] ADDR_FTT = 8'h14;
  localparam logic [7:0] ADDR_TRG = 8'h18;
  localparam logic [7:0] ADDR_EFC = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  // field positions
  localparam int LFC_STOP = 2;
  localparam int LFC_PEN = 3;
  localparam int LFC_PTYPE = 4;
  localparam int LFC_PFORCE = 5;
  localparam int LFC_BRK = 6;
  localparam int LFC_DLAB = 7;
  localparam int MOC_DTR = 0;
  localparam int MOC_RTS = 1;
  localparam int FTT_TSEL = 7;
  localparam int EFC_ARTS = 6;
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0] TRG_RST = 8'h01;
  // trigger tables other than the programmable one: (sel+1) << shift
  localparam logic [1:0] TBL_PROG = 2'b11;
  localparam int TRIG_SHIFT = 2;
  // word length base and stop length in half-bit units
  localparam logic [3:0] NBITS_BASE = 4'h5;
  localparam logic [2:0] HALF_BIT = 3'h2;
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONEHALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic [3:0] nbits;
    logic [2:0] stop_halves;
    logic par_en;
    logic par_type;
    logic par_force;
  } fmt_t;

  typedef struct packed {
    logic frame_err;
    logic par_err;
    logic [7:0] data;
  } rx_word_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_DATA = 5'b00100,
    S_PAR = 5'b01000,
    S_STOP = 5'b10000
  } ser_state_t;
endpackage : uart_fmt_pkg

// file: verif/uart_fmt_checker.sv
// port-level assertions for the uart line-format block
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module uart_fmt_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd,
  input wire logic rxd,
  input wire logic dtr_n,
  input wire logic rts_n
);
  import uart_fmt_pkg::*;
  logic [7:0] lfc_r;
  logic [7:0] moc_r;
  logic [7:0] efc_r;
  logic wr_hit;
  logic bad_addr;
  logic rd_acc;

  // shadow copies change on the same edge as the real registers
  assign wr_hit = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign bad_addr = (paddr > ADDR_STAT) || (paddr[1:0] != 2'b00);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfc_r <= REG_RST;
      moc_r <= REG_RST;
      efc_r <= REG_RST;
    end else if (wr_hit) begin
      if (paddr == ADDR_LFC) lfc_r <= pwdata[7:0];
      if (paddr == ADDR_MOC) moc_r <= pwdata[7:0];
      if (paddr == ADDR_EFC) efc_r <= pwdata[7:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  dtr_follow_a: assert property (dtr_n == ~$past(moc_r[MOC_DTR]))
    else $error("dtr_n not inverse of its control bit");
  rts_manual_a: assert property (!$past(efc_r[EFC_ARTS]) |->
    rts_n == ~$past(moc_r[MOC_RTS]))
    else $error("rts_n not inverse of its control bit");
  break_low_a: assert property (lfc_r[LFC_BRK] |-> !txd)
    else $error("txd high during break");
  idle_high_a: assert property ($rose(resetn) |-> txd [*2])
    else $error("txd not idle high after reset");
  err_flag_a: assert property (psel && penable && bad_addr |-> pslverr)
    else $error("unmapped access without error");
  no_err_a: assert property (psel && penable && !bad_addr |-> !pslverr)
    else $error("error on a mapped access");
  rd_ready_a: assert property (rd_acc |-> pready)
    else $error("read access stalled");
  bad_rd_zero_a: assert property (rd_acc && bad_addr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  divh_zero_a: assert property (rd_acc && paddr == ADDR_DIVH &&
    !lfc_r[LFC_DLAB] |-> prdata == 32'h0)
    else $error("divisor high visible with access off");
  lfc_back_a: assert property (rd_acc && paddr == ADDR_LFC |->
    prdata[7:0] == lfc_r)
    else $error("line format readback differs");

  // main scenarios reached
  cover property (lfc_r[LFC_BRK] && !txd);
  cover property (psel && penable && pslverr);
  cover property (psel && penable && !pready);
  cover property (efc_r[EFC_ARTS] && moc_r[MOC_RTS] && rts_n);
endmodule : uart_fmt_checker

bind uart_line_format_control uart_fmt_checker chk (.clk(clk),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .rxd(rxd), .dtr_n(dtr_n), .rts_n(rts_n));

// file: verif/serial_peer.sv
// remote uart model on the serial line, half-bit resolution
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module serial_peer #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  // the line idles at mark between frames
  initial rxd = 1'b1;

  // drive a frame given as half-bit levels, lsb half first
  task automatic send(input logic [63:0] v, input int len);
    // line levels change just after a rising edge only
    @(posedge clk);
    for (int k = 0; k < len; k++) begin
      rxd <= v[k];
      repeat (DIV) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send

  // sample txd mid half-bit from the start edge; tolerates a clock of skew
  task automatic grab(input int len, output logic [63:0] v);
    v = '1;
    @(negedge txd);
    for (int k = 0; k < len; k++) begin
      repeat (k == 0 ? DIV / 2 : DIV) @(negedge clk);
      v[k] = txd;
    end
  endtask : grab
endmodule : serial_peer

// file: verif/tb.sv
// self-checking bench for the uart line-format block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end

////////////////////////////////////////////////////////////////////////////
module tb;
  import uart_fmt_pkg::*;
  localparam int DIV = 4;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic txd, rxd, dtr_n, rts_n, err, bp;
  logic [7:0] paddr, lf, d;
  logic [31:0] pwdata, prdata, q;
  logic [63:0] e1, e2, ex, got;
  logic [15:0] tab [7];
  int n_errors, n_compared, waits, l1, l2;

  uart_line_format_control #(.DEPTH(4)) dut (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txd(txd), .rxd(rxd), .dtr_n(dtr_n), .rts_n(rts_n));
  serial_peer #(.DIV(DIV)) peer (.clk(clk), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // one apb transfer, then an idle cycle so signals change once per edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] dd);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= dd;
    @(posedge clk);
    penable <= 1'b1;
    waits = 0;
    @(posedge clk);
    // no cap here: a hung slave is ended by the watchdog alone
    while (pready !== 1'b1) begin
      @(posedge clk);
      waits++;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    apb(1'b1, a, dd);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // expected line levels of one frame in half-bit steps, idle ones after
  function automatic logic [63:0] frame(input logic [7:0] f,
      input logic [7:0] dd, input logic bad, output int len);
    logic [63:0] v;
    int n;
    logic pb;
    v = '1;
    n = 5 + f[1:0];
    v[1:0] = 2'b00;
    len = 2;
    for (int i = 0; i < n; i++) begin
      v[len+:2] = {2{dd[i]}};
      len += 2;
    end
    pb = f[LFC_PFORCE] ? ~f[LFC_PTYPE] :
      ~(^(dd & ~(8'hff << n)) ^ f[LFC_PTYPE]);
    if (f[LFC_PEN]) begin
      v[len+:2] = {2{pb ^ bad}};
      len += 2;
    end
    len += !f[LFC_STOP] ? 2 : (n == 5 ? 3 : 4);
    return v;
  endfunction : frame

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // watchdog against a hung handshake or a missing frame
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; resetn = 1'b0; n_errors = 0; n_compared = 0;
    tab = '{16'h0015, 16'h03a5, 16'h040b, 16'h0a53, 16'h1d2c, 16'h2bc3,
      16'h3f5a};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(ADDR_LFC); `CHK(q[7:0], REG_RST)
    rd(ADDR_MOC); `CHK(q[7:0], REG_RST)
    `CHK({txd, dtr_n, rts_n}, 3'b111)
    // divisor latch behind the data addresses; high byte write ignored
    wr(ADDR_DIVH, 32'h55);
    wr(ADDR_LFC, 32'h80);
    wr(ADDR_DATA, DIV);
    rd(ADDR_DIVH); `CHK(q[7:0], 8'h00)
    rd(ADDR_DATA); `CHK(q[7:0], 8'h04)
    rd(8'h24); `CHK({err, q}, {1'b1, 32'h0})
    wr(8'h0d, 32'hff); `CHK(err, 1'b1)
    // modem outputs, every combination
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MOC, 32'(i));
      @(posedge clk);
      `CHK(dtr_n, ~i[0])
      `CHK(rts_n, ~i[1])
    end
    // seven formats from tab: two back-to-back frames out, one frame in
    for (int i = 0; i < 7; i++) begin
      {lf, d} = tab[i];
      wr(ADDR_LFC, {24'h0, lf});
      e1 = frame(lf, d, 1'b0, l1);
      e2 = frame(lf, ~d, 1'b0, l2);
      ex = e1 & ((e2 << l1) | ((64'h1 << l1) - 1));
      fork
        peer.grab(l1 + l2, got);
        begin
          wr(ADDR_DATA, {24'h0, d});
          wr(ADDR_DATA, {24'h0, ~d});
        end
      join
      `CHK(got, ex)
      bp = lf[LFC_PEN] & i[0];
      e1 = frame(lf, d, bp, l1);
      peer.send(e1, l1);
      repeat (2 * DIV) @(posedge clk);
      rd(ADDR_DATA);
      `CHK(q[9:0], {1'b0, bp, d & ~(8'hff << (5 + lf[1:0]))})
    end
    // programmable triggers and automatic request-to-send
    wr(ADDR_LFC, 32'h03);
    wr(ADDR_FTT, 32'hb0); wr(ADDR_TRG, 32'h05);
    wr(ADDR_FTT, 32'h30); wr(ADDR_TRG, 32'h02);
    rd(ADDR_TRG); `CHK(q[7:0], 8'h02)
    wr(ADDR_FTT, 32'hb0);
    rd(ADDR_TRG); `CHK(q[7:0], 8'h05)
    wr(ADDR_FTT, 32'h30);
    wr(ADDR_MOC, 32'h02); wr(ADDR_EFC, 32'h40);
    for (int i = 0; i < 2; i++) begin
      e1 = frame(8'h03, 8'h3c, 1'b0, l1);
      peer.send(e1, l1);
      repeat (2 * DIV) @(posedge clk);
      `CHK(rts_n, i[0])
    end
    rd(ADDR_DATA);
    @(posedge clk);
    `CHK(rts_n, 1'b0)
    rd(ADDR_DATA);
    wr(ADDR_EFC, 32'h0);
    // break holds the line and the queue; queue then fills and stalls
    wr(ADDR_LFC, 32'h43);
    for (int k = 0; k < 4; k++) wr(ADDR_DATA, 32'h11 * k);
    rd(ADDR_STAT); `CHK(q[5:0], 6'h04)
    `CHK(txd, 1'b0)
    `CHK(q[17], 1'b1)
    // fixed table: tx trigger (0+1)*4, so four queued is not below it
    wr(ADDR_FTT, 32'h0);
    rd(ADDR_STAT);
    `CHK(q[17], 1'b0)
    wr(ADDR_LFC, 32'h03);
    wr(ADDR_DATA, 32'h66);
    wr(ADDR_DATA, 32'h77);
    `CHK(waits > 20, 1'b1)
    rd(ADDR_STAT);
    for (int k = 0; k < 300 && q[5:0] !== 6'h00; k++) rd(ADDR_STAT);
    `CHK(q[5:0], 6'h00)
    repeat (100) @(posedge clk);
    `CHK(txd, 1'b1)
    finish_test();
  end
endmodule : tb
